// ### hw/pcout_pkg.sv
// package of the position compare output block
// holds register offsets, field positions, modes and timing constants
package pcout_pkg;
    // clock and timing
    localparam int CLK_NS = 50;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = (US_NS + CLK_NS - 1) / CLK_NS;
    localparam int COARSE_MS = 50;
    localparam int COARSE_US = COARSE_MS * 1000;
    localparam int COARSE_CYCLES = COARSE_US * (US_NS / CLK_NS);
    localparam int FINE_LIMIT_US = COARSE_US;
    localparam int PULSE_MAX_US = 1000000;
    localparam int LATENCY_NS = 500;
    localparam int LATENCY_CYCLES = LATENCY_NS / CLK_NS;
    // list geometry
    localparam int LIST_DEPTH = 512;
    localparam int LIST_AW = 9;
    localparam int POS_W = 32;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LIST_LEN = 8'h04;
    localparam logic [7:0] REG_INCREMENT = 8'h08;
    localparam logic [7:0] REG_PULSE_US = 8'h0c;
    localparam logic [7:0] REG_LIST_PTR = 8'h10;
    localparam logic [7:0] REG_LIST_DATA = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_EVENTS = 8'h1c;
    localparam logic [7:0] REG_TARGET = 8'h20;
    // control fields
    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_DISARM_BIT = 1;
    localparam int CTRL_STEPPER_BIT = 2;
    localparam int CTRL_SWAP_BIT = 3;
    localparam int CTRL_MODE_LSB = 4;
    // status fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_ACTIVE_BIT = 2;
    // output modes
    typedef enum logic [2:0] {
        output_mode_off = 3'h0,
        output_mode_pulse = 3'h1,
        output_mode_latched = 3'h2,
        output_mode_flip = 3'h3
    } pcout_mode_t;
    // list walker states
    typedef enum logic [1:0] {
        PCOUT_IDLE = 2'h0,
        PCOUT_FETCH = 2'h1,
        PCOUT_LOAD = 2'h2,
        PCOUT_RUN = 2'h3
    } pcout_state_t;
endpackage

// ### hw/pcout_mem.sv
// target position list memory, one write port and one registered read port
// assumes writes and reads come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module pcout_mem #(
    parameter int DEPTH = 512,
    parameter int AW = 9,
    parameter int W = 32
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [DEPTH];

    // ========================================
    // write and registered read
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ### hw/pcout_pulse.sv
// one-shot pulse timer for the compare output
// assumes start is a one-cycle strobe and period_us is stable around it
`timescale 1ns/10ps
`default_nettype none
module pcout_pulse import pcout_pkg::*; #(
    parameter int COARSE_CYC = COARSE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic start,
    input wire logic [19:0] period_us,
    output logic busy
);
    typedef struct packed {
        logic coarse;
        logic [19:0] units;
        logic [19:0] sub;
        logic busy;
    } pcout_pulse_t;

    pcout_pulse_t s;
    pcout_pulse_t next_s;
    logic [19:0] unit_len;

    // ========================================
    // unit counting, fine below the limit and coarse at or above it
    always_comb begin
        next_s = s;
        unit_len = s.coarse ? 20'(COARSE_CYC) : 20'(US_CYCLES);
        if (start) begin
            next_s.busy = 1'b1;
            next_s.sub = '0;
            if (period_us < 20'(FINE_LIMIT_US)) begin // [R13]
                next_s.coarse = 1'b0;
                next_s.units = (period_us == '0) ? 20'h00001 : period_us; // [R12]
            end else begin
                next_s.coarse = 1'b1;
                next_s.units = 20'(period_us / 20'(COARSE_US)); // [R13]
            end
        end else if (s.busy) begin
            if (s.sub == unit_len - 20'h00001) begin
                next_s.sub = '0;
                next_s.units = s.units - 20'h00001;
                if (s.units == 20'h00001) begin
                    next_s.busy = 1'b0;
                end
            end else begin
                next_s.sub = s.sub + 20'h00001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;

    property p_pulse_start;
        @(posedge clk_sys) disable iff (!rstn) start |=> busy;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start"); // [R12]
endmodule
`default_nettype wire

// ### hw/pcout_top.sv
// position compare output unit with apb register access
// assumes positions are synchronous to clk_sys and the pin is open drain
// Summary of operation
// R1 - a list of up to 512 target positions is held in memory
// R2 - compare uses servo encoder position or stepper step count per setting
// R3 - arming aborts any compare in progress and resets list index to zero
// R4 - on equal position the output activates and the next target loads
// R5 - after the final list event the done flag is set
// R6 - host sets fixed spacing with one entry, length one, and increment
// R7 - host spaces servo events at least one position update apart
// R8 - host spaces stepper events at least 1000 us apart
// R9 - off mode holds the output at its inactive level
// R10 - reset puts the output mode to off
// R11 - polarity swap exchanges the active level of the output
// R12 - pulse mode gives one pulse per event, 1 us to 1 s long
// R13 - pulse timer counts 1 us below 50 ms, else 50 ms steps
// R14 - latched mode turns output on at event until next arming
// R15 - flip mode inverts the output on every event
// R16 - output becomes active within half a microsecond of the match
// R17 - events are counted and the count is readable
// R18 - disarm request stops compare processing
// R19 - fixed spacing forms the next target by adding the signed increment
// R20 - arming clears the event count and the done flag
`timescale 1ns/10ps
`default_nettype none
module pcout_top import pcout_pkg::*; #(
    parameter int DEPTH = LIST_DEPTH,
    parameter int COARSE_CYC = COARSE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [POS_W-1:0] servo_position,
    input wire logic [POS_W-1:0] step_position,
    output logic cmp_pin_o,
    output logic cmp_pin_oe_n
);
    typedef struct packed {
        pcout_state_t state;
        logic [LIST_AW-1:0] index;
        logic [9:0] list_len;
        logic [POS_W-1:0] target;
        logic [POS_W-1:0] increment;
        pcout_mode_t mode;
        logic output_polarity_swap;
        logic stepper;
        logic [19:0] pulse_us;
        logic compare_done_flag;
        logic [31:0] events;
        logic level;
        logic [LIST_AW-1:0] list_ptr;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic pin_oe_n;
    } pcout_top_t;

    pcout_top_t s;
    pcout_top_t next_s;
    logic wr_access;
    logic compare_arm_flag;
    logic disarm;
    logic list_wr;
    logic [POS_W-1:0] position;
    logic match;
    logic fire;
    logic last;
    logic spaced;
    logic pulse_busy;
    logic active;
    logic [POS_W-1:0] mem_rd;

    // decode a register offset against the access address
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // clamp list length to the memory depth
    function automatic logic [9:0] clamp_len(input logic [31:0] v);
        clamp_len = (v > 32'(DEPTH)) ? 10'(DEPTH) : v[9:0];
    endfunction

    // ========================================
    // bus strobes and compare decision
    assign wr_access = psel && penable && s.pready && pwrite;
    assign compare_arm_flag = wr_access && hit(paddr, REG_CTRL) && pwdata[CTRL_ARM_BIT];
    assign disarm = wr_access && hit(paddr, REG_CTRL) && pwdata[CTRL_DISARM_BIT];
    assign list_wr = wr_access && hit(paddr, REG_LIST_DATA);
    assign position = s.stepper ? step_position : servo_position; // [R2]
    assign match = (s.state == PCOUT_RUN) && (position == s.target); // [R4]
    assign fire = match && !compare_arm_flag && !disarm;
    assign last = ({1'b0, s.index} + 10'h001) >= s.list_len;
    assign spaced = (s.list_len == 10'h001) && (s.increment != '0); // [R6]
    assign active = (s.mode == output_mode_pulse) ? pulse_busy : s.level;

    // ========================================
    // target list storage
    pcout_mem #(
        .DEPTH(DEPTH),
        .AW(LIST_AW),
        .W(POS_W)
    ) u_mem (
        .clk_sys(clk_sys),
        .wr_en(list_wr), // [R1]
        .wr_addr(s.list_ptr),
        .wr_data(pwdata),
        .rd_addr(s.index),
        .rd_data(mem_rd)
    );

    // ========================================
    // one-shot pulse timer
    pcout_pulse #(
        .COARSE_CYC(COARSE_CYC)
    ) u_pulse (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(fire && (s.mode == output_mode_pulse)), // [R12]
        .period_us(s.pulse_us),
        .busy(pulse_busy)
    );

    // ========================================
    // next state: registers, list walker, output level
    always_comb begin
        next_s = s;
        // apb setup phase answers in the following access cycle
        next_s.pready = psel && !penable;
        next_s.pslverr = 1'b0;
        next_s.prdata = '0;
        if (psel && !penable) begin
            unique case (paddr)
                REG_CTRL: begin
                    next_s.prdata[CTRL_STEPPER_BIT] = s.stepper;
                    next_s.prdata[CTRL_SWAP_BIT] = s.output_polarity_swap;
                    next_s.prdata[CTRL_MODE_LSB +: 3] = s.mode;
                end
                REG_LIST_LEN: next_s.prdata[9:0] = s.list_len;
                REG_INCREMENT: next_s.prdata = s.increment;
                REG_PULSE_US: next_s.prdata[19:0] = s.pulse_us;
                REG_LIST_PTR: next_s.prdata[LIST_AW-1:0] = s.list_ptr;
                REG_LIST_DATA: next_s.prdata = '0;
                REG_STATUS: begin
                    next_s.prdata[STAT_DONE_BIT] = s.compare_done_flag; // [R5]
                    next_s.prdata[STAT_BUSY_BIT] = (s.state != PCOUT_IDLE);
                    next_s.prdata[STAT_ACTIVE_BIT] = active;
                end
                REG_EVENTS: next_s.prdata = s.events; // [R17]
                REG_TARGET: next_s.prdata = s.target;
                default: next_s.pslverr = 1'b1;
            endcase
        end
        // register writes
        if (wr_access) begin
            if (hit(paddr, REG_CTRL)) begin
                next_s.stepper = pwdata[CTRL_STEPPER_BIT];
                next_s.output_polarity_swap = pwdata[CTRL_SWAP_BIT]; // [R11]
                next_s.mode = pcout_mode_t'(pwdata[CTRL_MODE_LSB +: 3]);
            end
            if (hit(paddr, REG_LIST_LEN)) begin
                next_s.list_len = clamp_len(pwdata);
            end
            if (hit(paddr, REG_INCREMENT)) begin
                next_s.increment = pwdata;
            end
            if (hit(paddr, REG_PULSE_US)) begin
                next_s.pulse_us = (pwdata > 32'(PULSE_MAX_US)) ? 20'(PULSE_MAX_US) : pwdata[19:0];
            end
            if (hit(paddr, REG_LIST_PTR)) begin
                next_s.list_ptr = pwdata[LIST_AW-1:0];
            end
            if (list_wr) begin
                next_s.list_ptr = s.list_ptr + 1'b1;
            end
        end
        // list walker
        unique case (s.state)
            PCOUT_IDLE: ;
            PCOUT_FETCH: next_s.state = PCOUT_LOAD;
            PCOUT_LOAD: begin
                next_s.target = mem_rd; // [R4]
                next_s.state = PCOUT_RUN;
            end
            PCOUT_RUN: begin
                if (fire) begin
                    next_s.events = s.events + 32'h00000001; // [R17]
                    if (spaced) begin
                        next_s.target = s.target + s.increment; // [R19]
                    end else if (last) begin
                        next_s.compare_done_flag = 1'b1; // [R5]
                        next_s.state = PCOUT_IDLE;
                    end else begin
                        next_s.index = s.index + 1'b1; // [R4]
                        next_s.state = PCOUT_FETCH;
                    end
                end
            end
        endcase
        // output level per mode
        if (fire) begin
            unique case (s.mode)
                output_mode_latched: next_s.level = 1'b1; // [R14]
                output_mode_flip: next_s.level = !s.level; // [R15]
                default: next_s.level = s.level;
            endcase
        end
        if (s.mode == output_mode_off) begin
            next_s.level = 1'b0; // [R9]
        end
        // arming restarts, disarming stops
        if (compare_arm_flag) begin
            next_s.index = '0; // [R3]
            next_s.events = '0; // [R20]
            next_s.compare_done_flag = 1'b0; // [R20]
            next_s.level = 1'b0;
            next_s.state = (next_s.list_len == '0) ? PCOUT_IDLE : PCOUT_FETCH; // [R3]
        end else if (disarm) begin
            next_s.state = PCOUT_IDLE; // [R18]
        end
        // pin drives low when active, swapped when polarity is exchanged
        next_s.pin_oe_n = !(((s.mode != output_mode_off) && active)
            ^ s.output_polarity_swap); // [R9] [R11] [R16]
    end

    // ========================================
    // state register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s <= '0; // [R10]
            s.mode <= output_mode_off; // [R10]
            s.pin_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign cmp_pin_o = 1'b0;
    assign cmp_pin_oe_n = s.pin_oe_n;

    // ========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    localparam int LAT_MAX = LATENCY_CYCLES;

    sequence s_refetch;
        (s.state == PCOUT_FETCH) ##1 (s.state == PCOUT_LOAD) ##1 (s.state == PCOUT_RUN);
    endsequence

    property p_arm_index;
        compare_arm_flag && (next_s.list_len != '0) |=> (s.index == '0) && (s.state == PCOUT_FETCH);
    endproperty
    a_arm_index: assert property (p_arm_index) else $error("arm did not restart list"); // [R3]

    property p_arm_clear;
        compare_arm_flag |=> (s.events == '0) && !s.compare_done_flag;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm did not clear progress"); // [R20]

    property p_next_target;
        fire && !spaced && !last |=> s_refetch;
    endproperty
    a_next_target: assert property (p_next_target) else $error("next target not loaded"); // [R4]

    property p_spacing;
        fire && spaced |=> s.target == $past(s.target) + $past(s.increment);
    endproperty
    a_spacing: assert property (p_spacing) else $error("increment not applied"); // [R19]

    property p_done;
        fire && !spaced && last |=> s.compare_done_flag && (s.state == PCOUT_IDLE);
    endproperty
    a_done: assert property (p_done) else $error("done flag not set"); // [R5]

    property p_off_level;
        s.mode == output_mode_off |=> cmp_pin_oe_n == !$past(s.output_polarity_swap);
    endproperty
    a_off_level: assert property (p_off_level) else $error("off mode output not inactive"); // [R9]

    property p_reset_mode;
        @(posedge clk_sys) disable iff (1'b0) !rstn |=> (s.mode == output_mode_off) && cmp_pin_oe_n;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset did not select off"); // [R10]

    property p_latency;
        fire && ((s.mode == output_mode_latched) || (s.mode == output_mode_pulse))
            && (s.pulse_us != '0) |-> ##[1:LAT_MAX] (cmp_pin_oe_n == s.output_polarity_swap);
    endproperty
    a_latency: assert property (p_latency) else $error("output late after match"); // [R16]

    property p_flip;
        fire && (s.mode == output_mode_flip) |=> s.level != $past(s.level);
    endproperty
    a_flip: assert property (p_flip) else $error("flip mode did not invert"); // [R15]

    property p_latch_hold;
        (s.mode == output_mode_latched) && s.level && !compare_arm_flag && $stable(s.mode)
            |=> s.level || (s.mode != output_mode_latched);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched output dropped"); // [R14]

    property p_count;
        fire |=> s.events == $past(s.events) + 32'h00000001;
    endproperty
    a_count: assert property (p_count) else $error("event not counted"); // [R17]

    property p_disarm;
        disarm && !compare_arm_flag |=> (s.state == PCOUT_IDLE) [*2];
    endproperty
    a_disarm: assert property (p_disarm) else $error("disarm did not stop compare"); // [R18]

    // a match on the servo source is taken when servo is selected
    property p_servo_select;
        !s.stepper && (s.state == PCOUT_RUN) && (servo_position == s.target) && !wr_access
            |=> s.events == $past(s.events) + 32'h00000001;
    endproperty
    a_servo_select: assert property (p_servo_select) else $error("servo match missed"); // [R2]

    // a match on the step count is taken when stepper is selected
    property p_stepper_select;
        s.stepper && (s.state == PCOUT_RUN) && (step_position == s.target) && !wr_access
            |=> s.events == $past(s.events) + 32'h00000001;
    endproperty
    a_stepper_select: assert property (p_stepper_select) else $error("step match missed"); // [R2]

    property p_done_hold;
        s.compare_done_flag && !compare_arm_flag |=> s.compare_done_flag;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done flag lost"); // [R5]

    property p_off_drop;
        s.mode == output_mode_off |=> !s.level;
    endproperty
    a_off_drop: assert property (p_off_drop) else $error("off mode kept a level"); // [R9]
endmodule
`default_nettype wire

// ### verif/pcout_load_model.sv
// load circuit model hanging on the open-drain compare pin
// assumes a pull-up on the wire and counts the cycles the pin sits low
`timescale 1ns/10ps
`default_nettype none
module pcout_load_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic pin_o,
    input wire logic pin_oe_n,
    output logic pin_level,
    output logic [31:0] low_cnt
);
    // ==========================================
    // wire level
    // released pin floats to the pull-up level
    assign pin_level = pin_oe_n ? 1'b1 : pin_o;

    // low time counter, one count per clock with the pin grounded
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            low_cnt <= 32'h0;
        end else if (pin_level == 1'b0) begin
            low_cnt <= low_cnt + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the position compare output unit
// assumes a 20 MHz clk_sys and a pulled-up load on the compare pin
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pcout_pkg::*;
    localparam int COARSE_T = 40;
    localparam int SERVO_GAP = 125 * US_CYCLES;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] servo_position = 32'h0;
    logic [31:0] step_position = 32'h0;
    logic cmp_pin_o;
    logic cmp_pin_oe_n;
    logic pin_level;
    logic [31:0] low_cnt;
    logic [31:0] rd;
    logic [31:0] base;
    logic er;
    int err_count = 0;
    int n_tests = 0;

    // ==========================================
    // clock, design and load
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    pcout_top #(.DEPTH(LIST_DEPTH), .COARSE_CYC(COARSE_T)) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_position(servo_position), .step_position(step_position),
        .cmp_pin_o(cmp_pin_o), .cmp_pin_oe_n(cmp_pin_oe_n)
    );

    pcout_load_model u_load (
        .clk_sys(clk_sys), .rstn(rstn), .pin_o(cmp_pin_o), .pin_oe_n(cmp_pin_oe_n),
        .pin_level(pin_level), .low_cnt(low_cnt)
    );

    // ==========================================
    // helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    function automatic logic [31:0] ctl(pcout_mode_t m, logic sw, logic st, logic arm);
        return ({29'h0, m} << CTRL_MODE_LSB) | ({31'h0, sw} << CTRL_SWAP_BIT)
            | ({31'h0, st} << CTRL_STEPPER_BIT) | {31'h0, arm};
    endfunction

    // move one position source onto a value, then allow the output latency
    task automatic hit(input logic st, input logic [31:0] v);
        @(posedge clk_sys);
        if (st) begin
            step_position <= v;
        end else begin
            servo_position <= v;
        end
        cyc(LATENCY_CYCLES);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        cyc(40000);
        err_count++;
        tally_and_finish;
    end

    // ==========================================
    // scenarios
    initial begin
        cyc(20);
        rstn <= 1'b1;
        cyc(2);
        rd_chk("ctrl", REG_CTRL, 32'h0);
        rd_chk("status", REG_STATUS, 32'h0);
        rd_chk("events", REG_EVENTS, 32'h0);
        chk("pin idle", 32'h1, {31'h0, pin_level});
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        // swapped polarity in off mode grounds the pin
        wr(REG_CTRL, ctl(output_mode_off, 1'b1, 1'b0, 1'b0));
        cyc(3);
        chk("pin swapped", 32'h0, {31'h0, pin_level});
        wr(REG_CTRL, 32'h0);
        cyc(3);
        chk("pin unswapped", 32'h1, {31'h0, pin_level});
        wr(REG_LIST_LEN, 32'd600);
        rd_chk("len clamp", REG_LIST_LEN, 32'd512);
        // three entry list, latched output
        wr(REG_LIST_PTR, 32'h0);
        for (int i = 1; i <= 3; i++) begin
            wr(REG_LIST_DATA, 32'(100 * i));
        end
        rd_chk("list ptr", REG_LIST_PTR, 32'd3);
        wr(REG_LIST_LEN, 32'd3);
        wr(REG_CTRL, ctl(output_mode_latched, 1'b0, 1'b0, 1'b1));
        cyc(4);
        rd_chk("first target", REG_TARGET, 32'd100);
        hit(1'b1, 32'd100);
        rd_chk("servo only", REG_EVENTS, 32'h0);
        hit(1'b0, 32'd100);
        chk("pin on", 32'h0, {31'h0, pin_level});
        rd_chk("events 1", REG_EVENTS, 32'd1);
        rd_chk("next target", REG_TARGET, 32'd200);
        cyc(SERVO_GAP);
        hit(1'b0, 32'd200);
        chk("pin held", 32'h0, {31'h0, pin_level});
        rd_chk("not done", REG_STATUS, 32'h1 << STAT_BUSY_BIT | 32'h1 << STAT_ACTIVE_BIT);
        cyc(SERVO_GAP);
        hit(1'b0, 32'd300);
        cyc(2);
        rd_chk("done", REG_STATUS, 32'h1 << STAT_DONE_BIT | 32'h1 << STAT_ACTIVE_BIT);
        rd_chk("events 3", REG_EVENTS, 32'd3);
        // re-arm on the step count
        step_position <= 32'h0;
        wr(REG_CTRL, ctl(output_mode_latched, 1'b0, 1'b1, 1'b1));
        cyc(4);
        chk("pin rearmed", 32'h1, {31'h0, pin_level});
        rd_chk("events clr", REG_EVENTS, 32'h0);
        rd_chk("done clr", REG_STATUS, 32'h1 << STAT_BUSY_BIT);
        rd_chk("index zero", REG_TARGET, 32'd100);
        hit(1'b1, 32'd100);
        chk("step pin", 32'h0, {31'h0, pin_level});
        // disarm stops processing
        wr(REG_CTRL, ctl(output_mode_latched, 1'b0, 1'b1, 1'b0)
            | 32'h1 << CTRL_DISARM_BIT);
        hit(1'b1, 32'd200);
        rd_chk("disarm events", REG_EVENTS, 32'd1);
        rd_chk("disarm idle", REG_STATUS, 32'h1 << STAT_ACTIVE_BIT);
        // fixed spacing with a negative step, flip output
        wr(REG_LIST_PTR, 32'h0);
        wr(REG_LIST_DATA, 32'd30);
        wr(REG_LIST_LEN, 32'd1);
        wr(REG_INCREMENT, 32'hffff_fffb);
        rd_chk("increment", REG_INCREMENT, 32'hffff_fffb);
        wr(REG_CTRL, ctl(output_mode_flip, 1'b0, 1'b0, 1'b1));
        cyc(4);
        for (int i = 0; i < 3; i++) begin
            cyc(SERVO_GAP);
            hit(1'b0, 32'(30 - 5 * i));
            chk("flip pin", 32'(i % 2), {31'h0, pin_level});
        end
        rd_chk("spaced events", REG_EVENTS, 32'd3);
        rd_chk("spaced target", REG_TARGET, 32'd15);
        rd_chk("spaced busy", REG_STATUS, 32'h1 << STAT_BUSY_BIT | 32'h1 << STAT_ACTIVE_BIT);
        // one-shot, fine then coarse resolution
        wr(REG_INCREMENT, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wr(REG_PULSE_US, k ? 32'(COARSE_MS * 1000) : 32'd3);
            wr(REG_LIST_PTR, 32'h0);
            wr(REG_LIST_DATA, 32'(50 + k));
            wr(REG_CTRL, ctl(output_mode_pulse, 1'b0, 1'b0, 1'b1));
            cyc(4);
            chk("pulse idle", 32'h1, {31'h0, pin_level});
            base = low_cnt;
            hit(1'b0, 32'(50 + k));
            chk("pulse on", 32'h0, {31'h0, pin_level});
            cyc(80);
            chk("pulse len", k ? 32'(COARSE_T) : 32'(3 * US_CYCLES), low_cnt - base);
        end
        wr(REG_PULSE_US, 32'd2000000);
        rd_chk("pulse clamp", REG_PULSE_US, 32'd1000000);
        tally_and_finish;
    end
endmodule
`default_nettype wire
